//--- pkg/ssw_params.svh
// Functional notes
// - Ignore SYSREF within positive window after edge
// - Windows act only with auto phase enabled
// - Positive codes: zero, half, one, one-half clocks
// - Negative code 11 ignores 1.5 clocks before
// - Read-only 4-bit captured divider phase status
// - Zero windows: offset equals captured phase
// - 3-bit delay mode, reset 000 no delay
// - Mode 010 fine delay, steps 0-16
// - Mode 011 low-jitter fine, steps 0-16
// - Mode 100 fine delay, all 192 steps
// - Mode 110 fine plus superfine, full ranges
// - Ignore SYSREF within negative window before edge
// - Auto enable realigns divider; else unchanged
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define SSW_IDX_DIV_RATIO 10'h108
`define SSW_IDX_DIV_CTRL 10'h10a
`define SSW_IDX_DIV_STATUS 10'h10b
`define SSW_IDX_DELAY_CTRL 10'h110
`define SSW_IDX_SYSREF_MODE 10'h120
`define SSW_IDX_PHASE_CAP 10'h129

// ==========================================================
// Field positions
`define SSW_AUTO_BIT 7
`define SSW_NEG_HI 3
`define SSW_NEG_LO 2
`define SSW_POS_HI 1
`define SSW_POS_LO 0
`define SSW_NIB_HI 3
`define SSW_MODE_HI 2
`define SSW_SMODE_HI 2
`define SSW_SMODE_LO 1

// ==========================================================
// Reset values
`define SSW_RATIO_RST 3'h1
`define SSW_WIN_RST 2'h0
`define SSW_NIB_RST 4'h0
`define SSW_MODE_RST 3'h0
`define SSW_SMODE_RST 2'h0
`define SSW_CNT_RST 3'h0
`define SSW_ZERO32 32'h0000_0000

// ==========================================================
// Delay mode codes
`define SSW_DLY_NONE 3'h0
`define SSW_DLY_FINE16 3'h2
`define SSW_DLY_FINE16_LJ 3'h3
`define SSW_DLY_FINE192 3'h4
`define SSW_DLY_FINE_SUPER 3'h6

`endif

//--- pkg/ssw_pkg.sv
package ssw_pkg;

  typedef enum logic [1:0] {
    SSW_APB_IDLE = 2'b01,
    SSW_APB_ACCESS = 2'b10
  } ssw_apb_state_type;

  typedef logic [3:0] ssw_half_type;

endpackage

//--- pkg/ssw_skew_if.sv
`timescale 1ns/1ps
interface ssw_skew_if;
  ssw_pkg::ssw_half_type phase_half;
  logic [4:0] period_half;
  logic [1:0] pos_win;
  logic [1:0] neg_win;
  logic ignore;

  modport top
  (
    output phase_half,
    output period_half,
    output pos_win,
    output neg_win,
    input ignore
  );

  modport filter
  (
    input phase_half,
    input period_half,
    input pos_win,
    input neg_win,
    output ignore
  );
endinterface

//--- rtl/ssw_skew_filter.sv
`timescale 1ns/1ps
`include "ssw_params.svh"
module ssw_skew_filter (
  // Window check
  ssw_skew_if.filter win
);

  // ==========================================================
  // Distances in half device clocks after the last divider edge and before the next one
  wire logic [4:0] after_edge;
  wire logic [4:0] before_edge;
  wire logic in_pos;
  wire logic in_neg;

  assign after_edge = {1'b0, win.phase_half};
  assign before_edge = win.period_half - after_edge;
  // Code value is the window width in half clocks, code 0 admits only the exact edge
  assign in_pos = after_edge <= {3'h0, win.pos_win};
  assign in_neg = before_edge <= {3'h0, win.neg_win};
  assign win.ignore = in_pos | in_neg;

endmodule

//--- rtl/ssw_top.sv
`timescale 1ns/1ps
`include "ssw_params.svh"
module ssw_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // SYSREF from the clock generator
  input wire logic sysref_in,
  input wire logic sysref_late,
  // Divider state
  output logic [2:0] div_phase,
  output logic realign_pulse,
  output logic sysref_ignored,
  // Sample clock delay path enables
  output logic fine_delay_en,
  output logic fine_full_range,
  output logic fine_low_jitter,
  output logic superfine_delay_en
);

  // ==========================================================
  // Functions
  function automatic logic [2:0] ssw_wrap_inc(input logic [2:0] cnt, input logic [2:0] ratio);
    logic [2:0] res;
    res = `SSW_CNT_RST;
    if (cnt < ratio)
    begin
      res = cnt + 3'h1;
    end
    return res;
  endfunction

  function automatic logic ssw_is_idx(input logic [11:0] addr, input logic [9:0] idx);
    return (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // ==========================================================
  // Registers
  ssw_pkg::ssw_apb_state_type state_reg;
  ssw_pkg::ssw_apb_state_type state_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic pslverr_next;
  logic auto_en_reg;
  logic [1:0] neg_win_reg;
  logic [1:0] pos_win_reg;
  logic [3:0] offset_reg;
  logic [3:0] offset_next;
  logic [3:0] phase_cap_reg;
  logic [2:0] delay_mode_reg;
  logic [2:0] div_ratio_reg;
  logic [1:0] sysref_mode_reg;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic sysref_d_reg;
  logic realign_reg;
  logic ignored_reg;
  logic fine_en_reg;
  logic fine_full_reg;
  logic fine_lj_reg;
  logic superfine_reg;

  // ==========================================================
  // APB decode
  wire logic setup_phase;
  wire logic access_done;
  wire logic wr_en;
  wire logic hit_ratio;
  wire logic hit_ctrl;
  wire logic hit_status;
  wire logic hit_delay;
  wire logic hit_smode;
  wire logic hit_cap;
  wire logic addr_hit;
  wire logic [31:0] rd_mux;

  assign setup_phase = psel & ~penable & (state_reg == ssw_pkg::SSW_APB_IDLE);
  assign access_done = psel & penable & pready_reg;
  assign hit_ratio = ssw_is_idx(paddr, `SSW_IDX_DIV_RATIO);
  assign hit_ctrl = ssw_is_idx(paddr, `SSW_IDX_DIV_CTRL);
  assign hit_status = ssw_is_idx(paddr, `SSW_IDX_DIV_STATUS);
  assign hit_delay = ssw_is_idx(paddr, `SSW_IDX_DELAY_CTRL);
  assign hit_smode = ssw_is_idx(paddr, `SSW_IDX_SYSREF_MODE);
  assign hit_cap = ssw_is_idx(paddr, `SSW_IDX_PHASE_CAP);
  assign addr_hit = hit_ratio | hit_ctrl | hit_status | hit_delay | hit_smode | hit_cap;
  // Writes to read-only registers are dropped silently, only unmapped addresses flag an error
  assign wr_en = access_done & pwrite & ~pslverr_reg;

  // Reserved bits read as zero
  assign rd_mux = hit_ratio ? {29'h0000_0000, div_ratio_reg} :
                  hit_ctrl ? {24'h00_0000, auto_en_reg, 3'h0, neg_win_reg, pos_win_reg} :
                  hit_status ? {28'h000_0000, offset_reg} :
                  hit_delay ? {29'h0000_0000, delay_mode_reg} :
                  hit_smode ? {29'h0000_0000, sysref_mode_reg, 1'b0} :
                  hit_cap ? {28'h000_0000, phase_cap_reg} :
                  `SSW_ZERO32;

  assign state_next = setup_phase ? ssw_pkg::SSW_APB_ACCESS :
                      access_done ? ssw_pkg::SSW_APB_IDLE : state_reg;
  assign prdata_next = (setup_phase & ~pwrite) ? rd_mux : `SSW_ZERO32;
  assign pslverr_next = setup_phase & ~addr_hit;

  // ==========================================================
  // SYSREF capture and divider
  ssw_skew_if skew_if ();

  wire logic sysref_rise;
  wire logic capture;
  wire logic realign;
  wire logic [3:0] ratio_plus;

  assign sysref_rise = sysref_in & ~sysref_d_reg;
  // Capture only while SYSREF mode is on and auto phase adjust is set
  assign capture = sysref_rise & (sysref_mode_reg != `SSW_SMODE_RST) & auto_en_reg;
  assign realign = capture & ~skew_if.ignore;
  assign ratio_plus = {1'b0, div_ratio_reg} + 4'h1;

  assign skew_if.phase_half = {cnt_reg, sysref_late};
  assign skew_if.period_half = {ratio_plus, 1'b0};
  assign skew_if.pos_win = pos_win_reg;
  assign skew_if.neg_win = neg_win_reg;

  ssw_skew_filter u_filter (
    .win(skew_if.filter)
  );

  // Realign places phase zero on the SYSREF cycle; a late half can not be removed on one clock
  assign cnt_next = realign ? ssw_wrap_inc(`SSW_CNT_RST, div_ratio_reg) :
                    ssw_wrap_inc(cnt_reg, div_ratio_reg);
  // With both windows zero nothing but the exact edge is ignored, so offset tracks the capture
  assign offset_next = skew_if.ignore ? `SSW_NIB_RST : skew_if.phase_half;

  // ==========================================================
  // Delay mode decode
  wire logic m_fine16;
  wire logic m_fine16_lj;
  wire logic m_fine192;
  wire logic m_super;

  // Undefined codes match none of these and leave every path off
  assign m_fine16 = delay_mode_reg == `SSW_DLY_FINE16;
  assign m_fine16_lj = delay_mode_reg == `SSW_DLY_FINE16_LJ;
  assign m_fine192 = delay_mode_reg == `SSW_DLY_FINE192;
  assign m_super = delay_mode_reg == `SSW_DLY_FINE_SUPER;

  // ==========================================================
  // APB slave flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ssw_pkg::SSW_APB_IDLE;
      prdata_reg <= `SSW_ZERO32;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      prdata_reg <= prdata_next;
      pready_reg <= setup_phase;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      auto_en_reg <= 1'b0;
      neg_win_reg <= `SSW_WIN_RST;
      pos_win_reg <= `SSW_WIN_RST;
      delay_mode_reg <= `SSW_MODE_RST;
      div_ratio_reg <= `SSW_RATIO_RST;
      sysref_mode_reg <= `SSW_SMODE_RST;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
      begin
        auto_en_reg <= pwdata[`SSW_AUTO_BIT];
        neg_win_reg <= pwdata[`SSW_NEG_HI:`SSW_NEG_LO];
        pos_win_reg <= pwdata[`SSW_POS_HI:`SSW_POS_LO];
      end
      if (hit_delay)
      begin
        delay_mode_reg <= pwdata[`SSW_MODE_HI:0];
      end
      if (hit_ratio)
      begin
        div_ratio_reg <= pwdata[`SSW_MODE_HI:0];
      end
      if (hit_smode)
      begin
        sysref_mode_reg <= pwdata[`SSW_SMODE_HI:`SSW_SMODE_LO];
      end
    end
  end

  // ==========================================================
  // Divider and capture state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= `SSW_CNT_RST;
      sysref_d_reg <= 1'b0;
      offset_reg <= `SSW_NIB_RST;
      phase_cap_reg <= `SSW_NIB_RST;
      realign_reg <= 1'b0;
      ignored_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      sysref_d_reg <= sysref_in;
      realign_reg <= realign;
      ignored_reg <= capture & skew_if.ignore;
      if (capture)
      begin
        phase_cap_reg <= skew_if.phase_half;
        offset_reg <= offset_next;
      end
    end
  end

  // ==========================================================
  // Delay path enables
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fine_en_reg <= 1'b0;
      fine_full_reg <= 1'b0;
      fine_lj_reg <= 1'b0;
      superfine_reg <= 1'b0;
    end
    else
    begin
      fine_en_reg <= m_fine16 | m_fine16_lj | m_fine192 | m_super;
      fine_full_reg <= m_fine192 | m_super;
      fine_lj_reg <= m_fine16_lj;
      superfine_reg <= m_super;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign div_phase = cnt_reg;
  assign realign_pulse = realign_reg;
  assign sysref_ignored = ignored_reg;
  assign fine_delay_en = fine_en_reg;
  assign fine_full_range = fine_full_reg;
  assign fine_low_jitter = fine_lj_reg;
  assign superfine_delay_en = superfine_reg;

endmodule

//--- bench/ssw_sysref_gen.sv
`timescale 1ns/1ps
// ==========
// Clock generator side: SYSREF source
module ssw_sysref_gen (
  // Clock
  input wire logic clk,
  // SYSREF to the converter
  output logic sysref_in,
  output logic sysref_late
);
  initial
  begin
    sysref_in = 1'b0;
    sysref_late = 1'b0;
  end
  // Late flag is inverted outside the edge so a stale value never passes as valid
  task automatic fire(input logic late);
    @(posedge clk);
    sysref_in <= 1'b1;
    sysref_late <= late;
    @(posedge clk);
    sysref_in <= 1'b0;
    sysref_late <= ~late;
  endtask
endmodule

//--- bench/ssw_top_chk.sv
`timescale 1ns/1ps
// ==========
// Port checks
module ssw_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // SYSREF and divider
  input wire logic sysref_in,
  input wire logic [2:0] div_phase,
  input wire logic realign_pulse,
  input wire logic sysref_ignored,
  // Delay enables
  input wire logic fine_delay_en,
  input wire logic fine_full_range,
  input wire logic fine_low_jitter,
  input wire logic superfine_delay_en
);
  wire [2:0] wmode = pwdata[2:0];
  wire [3:0] dly = {fine_delay_en, fine_full_range, fine_low_jitter, superfine_delay_en};
  wire pulse = realign_pulse | sysref_ignored;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  function automatic logic [3:0] dec(input logic [2:0] m);
    return m == 3'h2 ? 4'h8 : m == 3'h3 ? 4'ha : m == 3'h4 ? 4'hc : m == 3'h6 ? 4'hd : 4'h0;
  endfunction
  sequence s_dly_wr;
    psel && penable && pready && pwrite && paddr == 12'h440;
  endsequence
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_ready_setup: assert property (psel && !penable |=> pready) else $error("pready missing");
  chk_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
  chk_pulse_cause: assert property (pulse |-> $past(sysref_in) && !$past(sysref_in, 2))
    else $error("pulse without edge");
  chk_pulse_single: assert property (pulse |-> !(realign_pulse && sysref_ignored) ##1 !pulse)
    else $error("bad pulse shape");
  chk_realign_phase: assert property (realign_pulse |-> div_phase <= 3'h1)
    else $error("divider not realigned");
  chk_mode_decode: assert property (s_dly_wr |-> ##2 dly == dec($past(wmode, 2)))
    else $error("delay decode wrong");
endmodule
bind ssw_top ssw_top_chk chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sysref_in(sysref_in), .div_phase(div_phase), .realign_pulse(realign_pulse),
  .sysref_ignored(sysref_ignored), .fine_delay_en(fine_delay_en), .fine_full_range(fine_full_range),
  .fine_low_jitter(fine_low_jitter), .superfine_delay_en(superfine_delay_en));

//--- bench/ssw_top_tb.sv
`timescale 1ns/1ps
// ==========
// Bench
module ssw_top_tb;
  logic clk, rst, psel, penable, pwrite, sysref_in, sysref_late;
  logic pready, pslverr, realign_pulse, sysref_ignored, erv, ign;
  logic fine_delay_en, fine_full_range, fine_low_jitter, superfine_delay_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] div_phase;
  logic [3:0] ph, last_st;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Rows: mode code, then expected {fine, full, low jitter, superfine}
  logic [6:0] rows [8] = '{7'h00, 7'h10, 7'h28, 7'h3a, 7'h4c, 7'h50, 7'h6d, 7'h70};
  wire [3:0] dly = {fine_delay_en, fine_full_range, fine_low_jitter, superfine_delay_en};
  ssw_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysref_in(sysref_in),
    .sysref_late(sysref_late), .div_phase(div_phase), .realign_pulse(realign_pulse),
    .sysref_ignored(sysref_ignored), .fine_delay_en(fine_delay_en), .fine_full_range(fine_full_range),
    .fine_low_jitter(fine_low_jitter), .superfine_delay_en(superfine_delay_en));
  ssw_sysref_gen gen_u (.clk(clk), .sysref_in(sysref_in), .sysref_late(sysref_late));
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("counts cmp=%0d err=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready, data and error are all taken at the edge that sees ready high
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdv, e);
    cmp(32'(erv), 32'h0000_0000);
  endtask
  // Phase is read in the cycle SYSREF is high, which is what the capture edge sees
  task automatic shot(input logic [3:0] w, input logic on);
    fork
      gen_u.fire(w[0]);
      begin
        @(posedge clk);
        #1;
        ph = {div_phase, w[0]};
      end
    join
    #1;
    ign = on && (ph <= 4'(w[1:0]) || 5'h10 - 5'(ph) <= 5'(w[3:2]));
    cmp(32'(realign_pulse), 32'(on && !ign));
    cmp(32'(sysref_ignored), 32'(ign));
    // Ratio is 7 in these tests, so a free-running divider wraps modulo 8
    if (on && !ign)
      cmp(32'(div_phase), 32'h0000_0001);
    else
      cmp(32'(div_phase), 32'(3'(ph[3:1] + 3'h1)));
    if (on)
      last_st = ign ? 4'h0 : ph;
    rdc(12'h42c, 32'(last_st));
    if (on)
      rdc(12'h4a4, 32'(ph));
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(12'h420, 32'h0000_0001);
    rdc(12'h428, 32'h0000_0000);
    rdc(12'h42c, 32'h0000_0000);
    rdc(12'h440, 32'h0000_0000);
    cmp(32'(dly), 32'h0000_0000);
    apb(1'b0, 12'h400, 32'h0000_0000);
    cmp(32'(erv), 32'h0000_0001);
    cmp(rdv, 32'h0000_0000);
    apb(1'b1, 12'h42c, 32'h0000_000f);
    rdc(12'h42c, 32'h0000_0000);
    apb(1'b1, 12'h428, 32'h0000_00ff);
    rdc(12'h428, 32'h0000_008f);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 12'h440, 32'hffff_fff8 | 32'(rows[i][6:4]));
      repeat (2) @(posedge clk);
      #1;
      cmp(32'(dly), 32'(rows[i][3:0]));
      rdc(12'h440, 32'(rows[i][6:4]));
    end
    $display("test delay modes done");
    apb(1'b1, 12'h420, 32'h0000_0007);
    for (int w = 0; w < 16; w++)
    begin
      apb(1'b1, 12'h480, 32'h0000_0000);
      apb(1'b1, 12'h428, 32'h0000_0080 | 32'(w));
      apb(1'b1, 12'h480, 32'h0000_0002);
      repeat (w) @(posedge clk);
      shot(4'(w), 1'b1);
    end
    $display("test skew windows done");
    apb(1'b1, 12'h480, 32'h0000_0000);
    apb(1'b1, 12'h428, 32'h0000_000f);
    apb(1'b1, 12'h480, 32'h0000_0002);
    shot(4'h0, 1'b0);
    $display("test auto off done");
    // Mid-run reset must bring every register and every enable back to its reset value; SYSREF mode is reset too but not read back
    apb(1'b1, 12'h440, 32'h0000_0006);
    repeat (2) @(posedge clk);
    #1;
    cmp(32'(dly), 32'h0000_000d);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(12'h4a4, 32'h0000_0000);
    rdc(12'h42c, 32'h0000_0000);
    rdc(12'h440, 32'h0000_0000);
    rdc(12'h428, 32'h0000_0000);
    rdc(12'h420, 32'h0000_0001);
    cmp(32'(dly), 32'h0000_0000);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
